// [rtl/rscl_pkg.sv]
// Package for the reset state and configuration latch block
package rscl_pkg;

  // ****************************************
  // Register map
  // ****************************************
  localparam logic [7:0] RSCL_CFG_IDX = 8'h3F;
  localparam logic [7:0] RSCL_PRIO_IDX = 8'h3C;
  localparam logic [7:0] RSCL_STAT_IDX = 8'h30;
  localparam logic [11:0] RSCL_CFG_ADDR = {2'h0, RSCL_CFG_IDX, 2'h0};
  localparam logic [11:0] RSCL_PRIO_ADDR = {2'h0, RSCL_PRIO_IDX, 2'h0};
  localparam logic [11:0] RSCL_STAT_ADDR = {2'h0, RSCL_STAT_IDX, 2'h0};

  // ****************************************
  // Reset values and vectors
  // ****************************************
  localparam logic [4:0] RSCL_TOP_IRQ_RST = 5'h06;
  localparam logic [7:0] RSCL_RAM_MAP_RST = 8'h00;
  localparam logic [15:0] RSCL_TMR_CNT_RST = 16'h0000;
  localparam logic [15:0] RSCL_OCMP_RST = 16'hFFFF;
  localparam logic [15:0] RSCL_BAUD_RST = 16'h0004;
  localparam logic [1:0] RSCL_WDOG_RATE_RST = 2'h0;
  localparam logic [15:0] RSCL_VEC_NORMAL = 16'hFFFE;
  localparam logic [15:0] RSCL_VEC_SPECIAL = 16'hBFFE;
  localparam logic [1:0] RSCL_FETCH_CYCLES = 2'h3;

  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [1:0] {
    RSCL_ST_HOLD = 2'b00,
    RSCL_ST_LOAD = 2'b01,
    RSCL_ST_FETCH = 2'b10,
    RSCL_ST_RUN = 2'b11
  } rscl_state_e;

  typedef enum logic [1:0] {
    RSCL_CAUSE_POR = 2'b00,
    RSCL_CAUSE_CLKMON = 2'b01,
    RSCL_CAUSE_WDOG = 2'b10
  } rscl_cause_e;

  // Bit order matches the configuration byte, bit 7 first
  typedef struct packed {
    logic rom_base_select;
    logic sync_serial_pin_select;
    logic fast_clock_output_enable;
    logic pullup_assign_enable;
    logic security_off;
    logic watchdog_off;
    logic rom_in_map;
    logic eeprom_in_map;
  } rscl_cfg_s;

  typedef struct packed {
    logic rom_at_4000;
    logic rom_at_0000;
    logic rom_in_map;
    logic eeprom_in_map;
    logic security_en;
    logic watchdog_en;
    logic fast_clock_oe;
    logic pullup_assign_en;
    logic i2c_on_port_d;
    logic i2c_on_port_e;
    logic spi_blocked;
  } rscl_map_s;

  typedef struct packed {
    logic ccr_x;
    logic ccr_i;
    logic ccr_s;
    logic [7:0] ram_reg_map_setup;
    logic eeprom_map_setup;
    logic expansion_bus;
    logic [15:0] timer_count;
    logic [15:0] ocmp_value;
    logic [15:0] baud;
    logic tx_holding_empty;
    logic tx_done;
    logic [1:0] watchdog_rate;
    logic osc_startup_delay;
    logic clk_monitor_en;
    logic clk_monitor_force;
    logic adc_power_up;
    logic irq_edge_mode;
  } rscl_init_s;

endpackage : rscl_pkg

// [rtl/rscl_top.sv]
// Reset sequencer with configuration latches, vector select and start-up state
//
// Overview of operation
// [R1] Configuration byte is EEPROM plus working latches; only latches steer the chip.
// [R2] Reads return the latch loaded at the last reset, not newer EEPROM data.
// [R3] Special variant allows direct writes; otherwise changes wait for next reset.
// [R4] ROM base bit picks high or low ROM; single chip reset forces it set.
// [R5] Pin select routes two-wire bus to port D and blocks SPI, else port E.
// [R6] Fast clock enable drives clock out on its pin; clear disables the pin.
// [R7] Pull-up assign enable gates the pull-up register; clear forces pull-ups off.
// [R8] Security off disables protection; clear enables it on mask parts.
// [R9] Watchdog off clear enables watchdog; reset selects the shortest watchdog rate.
// [R10] ROM and EEPROM map bits include or exclude each memory.
// [R11] Vector address depends on reset cause and normal or special mode.
// [R12] CPU fetches vector over three cycles; X, I and S flags set.
// [R13] Reset clears RAM/register map setup; EEPROM mapped at its fixed window.
// [R14] Expanded reset dedicates ports to bus; single chip makes all ports inputs.
// [R15] Timer count cleared, compares set to all ones, flags and enables cleared.
// [R16] Shared channel acts as compare 5 with no pin action.
// [R17] Periodic interrupt flag, mask and rate bits cleared at reset.
// [R18] Pulse accumulator, SPI and two-wire bus disabled at reset.
// [R19] Async serial baud set, interrupts masked, tx flags set, rx flags cleared.
// [R20] Converter power bit and conversion complete flag cleared at reset.
// [R21] Top interrupt select loaded with 00110; interrupt pins level-sensitive.
// [R22] Mode pins captured at reset release; delay set, clock monitor cleared.
// [R23] Latches load from EEPROM before the vector fetch begins.
//
// The implementer's own choice: the APB register port.
`timescale 1ns/1ns

module rscl_top (
  // Clock and reset
  input wire logic SYS_CLK_I,
  input wire logic RST_N_I,
  // Reset causes
  input wire logic PIN_RESET_I,
  input wire logic CLKMON_FAIL_I,
  input wire logic WDOG_TIMEOUT_I,
  // Mode pins and EEPROM configuration byte
  input wire logic MODE_PIN_A_I,
  input wire logic MODE_PIN_B_I,
  input wire logic [7:0] EEPROM_CFG_I,
  // CPU interrupt mask state
  input wire logic CPU_IMASK_I,
  // APB slave
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [11:0] PADDR_I,
  input wire logic [31:0] PWDATA_I,
  input wire logic [3:0] PSTRB_I,
  output logic PREADY_O,
  output logic [31:0] PRDATA_O,
  output logic PSLVERR_O,
  // Sequence to CPU and peripherals
  output logic PERIPH_RST_O,
  output logic CPU_FETCH_O,
  output logic CPU_RUN_O,
  output logic [15:0] VECTOR_ADDR_O,
  // Configuration and start-up state
  output rscl_pkg::rscl_cfg_s CFG_O,
  output rscl_pkg::rscl_map_s MAP_O,
  output rscl_pkg::rscl_init_s INIT_O,
  output logic [4:0] TOP_IRQ_SEL_O,
  output logic [2:0] MODE_O
);
  import rscl_pkg::*;

  // ****************************************
  // State
  // ****************************************
  rscl_state_e state_r;
  rscl_state_e state_nxt;
  rscl_cause_e cause_r;
  rscl_cause_e cause_nxt;
  rscl_cfg_s cfg_r;
  rscl_map_s map_r;
  rscl_init_s init_r;
  logic [1:0] fetch_cnt_r;
  logic boot_rom_read_r;
  logic special_variant_r;
  logic mode_select_a_r;
  logic [4:0] top_irq_r;
  logic periph_rst_r;
  logic fetch_r;
  logic run_r;
  logic [15:0] vector_r;
  logic pready_r;
  logic [31:0] prdata_r;
  logic pslverr_r;
  logic req_reset;
  logic single_chip_cap;
  logic wr_fire;
  logic rd_hit;
  logic [31:0] rd_data;

  // ****************************************
  // Reset sequence
  // ****************************************
  // Pin reset outranks clock monitor, which outranks the watchdog
  always_comb begin
    req_reset = 1'b1;
    cause_nxt = cause_r;
    if (PIN_RESET_I) begin
      cause_nxt = RSCL_CAUSE_POR; // [R11]
    end else if (CLKMON_FAIL_I) begin
      cause_nxt = RSCL_CAUSE_CLKMON; // [R11]
    end else if (WDOG_TIMEOUT_I && !cfg_r.watchdog_off) begin
      cause_nxt = RSCL_CAUSE_WDOG; // [R9]
    end else begin
      req_reset = 1'b0;
    end
  end

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      RSCL_ST_HOLD: begin
        if (!PIN_RESET_I) begin
          state_nxt = RSCL_ST_LOAD;
        end
      end
      RSCL_ST_LOAD: begin
        state_nxt = RSCL_ST_FETCH; // [R23]
      end
      RSCL_ST_FETCH: begin
        if (fetch_cnt_r == RSCL_FETCH_CYCLES - 2'h1) begin
          state_nxt = RSCL_ST_RUN; // [R12]
        end
      end
      RSCL_ST_RUN: begin
        state_nxt = RSCL_ST_RUN;
      end
      default: begin
        state_nxt = RSCL_ST_HOLD;
      end
    endcase
    if (req_reset) begin
      state_nxt = RSCL_ST_HOLD;
    end
  end

  always_ff @(posedge SYS_CLK_I) begin
    if (!RST_N_I) begin
      state_r <= RSCL_ST_HOLD;
      cause_r <= RSCL_CAUSE_POR;
    end else begin
      state_r <= state_nxt;
      cause_r <= cause_nxt;
    end
  end

  always_ff @(posedge SYS_CLK_I) begin
    if (!RST_N_I || state_r != RSCL_ST_FETCH) begin
      fetch_cnt_r <= 2'h0;
    end else begin
      fetch_cnt_r <= fetch_cnt_r + 2'h1;
    end
  end

  // ****************************************
  // Mode capture
  // ****************************************
  // Pins are sampled in the first cycle after release, never under reset itself
  assign single_chip_cap = MODE_PIN_B_I && !MODE_PIN_A_I;

  always_ff @(posedge SYS_CLK_I) begin
    if (!RST_N_I) begin
      boot_rom_read_r <= 1'b0;
      special_variant_r <= 1'b0;
      mode_select_a_r <= 1'b0;
    end else if (state_r == RSCL_ST_LOAD) begin
      boot_rom_read_r <= !MODE_PIN_B_I && !MODE_PIN_A_I; // [R22]
      special_variant_r <= !MODE_PIN_B_I; // [R22]
      mode_select_a_r <= MODE_PIN_A_I; // [R22]
    end else if (wr_fire && PADDR_I == RSCL_PRIO_ADDR && special_variant_r && PSTRB_I[0]) begin
      boot_rom_read_r <= PWDATA_I[7];
      special_variant_r <= PWDATA_I[6];
      mode_select_a_r <= PWDATA_I[5];
    end
  end

  always_ff @(posedge SYS_CLK_I) begin
    if (!RST_N_I || state_r == RSCL_ST_HOLD) begin
      top_irq_r <= RSCL_TOP_IRQ_RST; // [R21]
    end else if (wr_fire && PADDR_I == RSCL_PRIO_ADDR && CPU_IMASK_I && PSTRB_I[0]) begin
      top_irq_r <= PWDATA_I[4:0];
    end
  end

  // ****************************************
  // Configuration latches
  // ****************************************
  // The EEPROM byte is only looked at while loading, so later programming stays hidden
  always_ff @(posedge SYS_CLK_I) begin
    if (!RST_N_I) begin
      cfg_r <= '0;
    end else if (state_r == RSCL_ST_LOAD) begin
      cfg_r <= rscl_cfg_s'(EEPROM_CFG_I); // [R1] [R2] [R23]
      if (single_chip_cap) begin
        cfg_r.rom_base_select <= 1'b1; // [R4]
      end
    end else if (wr_fire && PADDR_I == RSCL_CFG_ADDR && special_variant_r && PSTRB_I[0]) begin
      cfg_r <= rscl_cfg_s'(PWDATA_I[7:0]); // [R3]
    end
  end

  // Decoded controls follow the latches one cycle later
  always_ff @(posedge SYS_CLK_I) begin
    if (!RST_N_I) begin
      map_r <= '0;
    end else begin
      map_r.rom_at_4000 <= cfg_r.rom_base_select; // [R4]
      map_r.rom_at_0000 <= !cfg_r.rom_base_select && mode_select_a_r; // [R4]
      map_r.rom_in_map <= cfg_r.rom_in_map; // [R10]
      map_r.eeprom_in_map <= cfg_r.eeprom_in_map; // [R10]
      map_r.security_en <= !cfg_r.security_off; // [R8]
      map_r.watchdog_en <= !cfg_r.watchdog_off; // [R9]
      map_r.fast_clock_oe <= cfg_r.fast_clock_output_enable; // [R6]
      map_r.pullup_assign_en <= cfg_r.pullup_assign_enable; // [R7]
      map_r.i2c_on_port_d <= cfg_r.sync_serial_pin_select; // [R5]
      map_r.i2c_on_port_e <= !cfg_r.sync_serial_pin_select; // [R5]
      map_r.spi_blocked <= cfg_r.sync_serial_pin_select; // [R5]
    end
  end

  // ****************************************
  // Start-up state
  // ****************************************
  // Peripherals stay in reset until the CPU runs, which clears their flags and enables
  always_ff @(posedge SYS_CLK_I) begin
    if (!RST_N_I) begin
      periph_rst_r <= 1'b1;
    end else begin
      periph_rst_r <= state_nxt != RSCL_ST_RUN; // [R15] [R16] [R17] [R18] [R20]
    end
  end

  always_ff @(posedge SYS_CLK_I) begin
    if (!RST_N_I || state_r == RSCL_ST_HOLD) begin
      init_r.ccr_x <= 1'b1; // [R12]
      init_r.ccr_i <= 1'b1; // [R12]
      init_r.ccr_s <= 1'b1; // [R12]
      init_r.ram_reg_map_setup <= RSCL_RAM_MAP_RST; // [R13]
      init_r.eeprom_map_setup <= 1'b1; // [R13]
      init_r.expansion_bus <= 1'b0;
      init_r.timer_count <= RSCL_TMR_CNT_RST; // [R15]
      init_r.ocmp_value <= RSCL_OCMP_RST; // [R15]
      init_r.baud <= RSCL_BAUD_RST; // [R19]
      init_r.tx_holding_empty <= 1'b1; // [R19]
      init_r.tx_done <= 1'b1; // [R19]
      init_r.watchdog_rate <= RSCL_WDOG_RATE_RST; // [R9]
      init_r.osc_startup_delay <= 1'b1; // [R22]
      init_r.clk_monitor_en <= 1'b0; // [R22]
      init_r.clk_monitor_force <= 1'b0; // [R22]
      init_r.adc_power_up <= 1'b0; // [R20]
      init_r.irq_edge_mode <= 1'b0; // [R21]
    end else if (state_r == RSCL_ST_LOAD) begin
      init_r.expansion_bus <= MODE_PIN_A_I; // [R14]
    end
  end

  // ****************************************
  // CPU vector fetch
  // ****************************************
  // Cause code doubles as the word offset below the base vector
  always_ff @(posedge SYS_CLK_I) begin
    if (!RST_N_I) begin
      fetch_r <= 1'b0;
      run_r <= 1'b0;
      vector_r <= RSCL_VEC_NORMAL;
    end else begin
      fetch_r <= state_nxt == RSCL_ST_FETCH; // [R12]
      run_r <= state_nxt == RSCL_ST_RUN; // [R12]
      if (state_r == RSCL_ST_LOAD) begin
        if (!MODE_PIN_B_I) begin
          vector_r <= RSCL_VEC_SPECIAL - {13'h0, cause_r, 1'b0}; // [R11]
        end else begin
          vector_r <= RSCL_VEC_NORMAL - {13'h0, cause_r, 1'b0}; // [R11]
        end
      end
    end
  end

  // ****************************************
  // APB slave
  // ****************************************
  // One wait state: ready rises in the second access cycle
  assign wr_fire = PSEL_I && PENABLE_I && pready_r && PWRITE_I;

  always_comb begin
    rd_hit = 1'b1;
    rd_data = 32'h0;
    case (PADDR_I)
      RSCL_CFG_ADDR: begin
        rd_data = {24'h0, cfg_r}; // [R2]
      end
      RSCL_PRIO_ADDR: begin
        rd_data = {24'h0, boot_rom_read_r, special_variant_r, mode_select_a_r, top_irq_r};
      end
      RSCL_STAT_ADDR: begin
        rd_data = {24'h0, 2'h0, state_r, 2'h0, cause_r};
      end
      default: begin
        rd_hit = 1'b0;
      end
    endcase
  end

  always_ff @(posedge SYS_CLK_I) begin
    if (!RST_N_I) begin
      pready_r <= 1'b0;
      prdata_r <= 32'h0;
      pslverr_r <= 1'b0;
    end else begin
      pready_r <= PSEL_I && PENABLE_I && !pready_r;
      pslverr_r <= PSEL_I && PENABLE_I && !pready_r && !rd_hit;
      if (PSEL_I && PENABLE_I && !pready_r && !PWRITE_I && rd_hit) begin
        prdata_r <= rd_data;
      end else begin
        prdata_r <= 32'h0;
      end
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  // Every output is a register, so consumers never see decode glitches
  assign PREADY_O = pready_r;
  assign PRDATA_O = prdata_r;
  assign PSLVERR_O = pslverr_r;
  assign PERIPH_RST_O = periph_rst_r;
  assign CPU_FETCH_O = fetch_r;
  assign CPU_RUN_O = run_r;
  assign VECTOR_ADDR_O = vector_r;
  assign CFG_O = cfg_r;
  assign MAP_O = map_r;
  assign INIT_O = init_r;
  assign TOP_IRQ_SEL_O = top_irq_r;
  assign MODE_O = {boot_rom_read_r, special_variant_r, mode_select_a_r};

endmodule : rscl_top

// [verification/rscl_eeprom_model.sv]
// EEPROM cell model that feeds the configuration byte to the latches
`timescale 1ns/1ns

module rscl_eeprom_model #(
  parameter logic [7:0] INIT_BYTE = 8'h35
) (
  // Clock and programming request
  input wire logic clk_i,
  input wire logic prog_i,
  input wire logic [7:0] data_i,
  // Cell contents
  output logic [7:0] cell_o
);
  // ****************************************
  // Cell storage
  // ****************************************
  // Programming changes only the cell; the latches see it at the next reset
  initial cell_o = INIT_BYTE;
  always @(posedge clk_i) begin
    if (prog_i) begin
      cell_o <= data_i;
    end
  end
endmodule : rscl_eeprom_model

// [verification/rscl_top_sva.sv]
// Checker for the reset sequencer and configuration latches
`timescale 1ns/1ns

module rscl_top_sva (
  // Clock, reset and straps
  input wire logic SYS_CLK_I,
  input wire logic RST_N_I,
  input wire logic MODE_PIN_A_I,
  input wire logic MODE_PIN_B_I,
  input wire logic [7:0] EEPROM_CFG_I,
  // APB
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [11:0] PADDR_I,
  input wire logic [31:0] PWDATA_I,
  input wire logic [3:0] PSTRB_I,
  input wire logic PREADY_O,
  input wire logic [31:0] PRDATA_O,
  // Sequence and state
  input wire logic PERIPH_RST_O,
  input wire logic CPU_FETCH_O,
  input wire logic CPU_RUN_O,
  input wire logic [15:0] VECTOR_ADDR_O,
  input wire rscl_pkg::rscl_cfg_s CFG_O,
  input wire rscl_pkg::rscl_map_s MAP_O,
  input wire rscl_pkg::rscl_init_s INIT_O,
  input wire logic [2:0] MODE_O
);
  import rscl_pkg::*;
  // ****************************************
  // Helpers and assertions
  // ****************************************
  rscl_cfg_s cfg_r;
  logic rst_r;
  always_ff @(posedge SYS_CLK_I) begin
    cfg_r <= CFG_O;
    rst_r <= RST_N_I;
  end
  default clocking cb @(posedge SYS_CLK_I); endclocking
  default disable iff (!RST_N_I);
  fetch_seq_a:
    assert property ($rose(CPU_FETCH_O) |-> CPU_FETCH_O[*3] ##1 (CPU_RUN_O && !CPU_FETCH_O))
    else $error("fetch not three cycles then run");
  periph_hold_a:
    assert property (PERIPH_RST_O != CPU_RUN_O)
    else $error("peripheral reset disagrees with run");
  cfg_load_a:
    assert property ($rose(CPU_FETCH_O) |->
      CFG_O == ($past(EEPROM_CFG_I) | {MODE_O == 3'h0, 7'h00}))
    else $error("latches not loaded before fetch");
  mode_cap_a:
    assert property ($rose(CPU_FETCH_O) |-> MODE_O == {!$past(MODE_PIN_B_I) &&
      !$past(MODE_PIN_A_I), !$past(MODE_PIN_B_I), $past(MODE_PIN_A_I)})
    else $error("mode bits not captured");
  vector_sel_a:
    assert property ($rose(CPU_FETCH_O) |-> VECTOR_ADDR_O[14] == !MODE_O[1] &&
      VECTOR_ADDR_O[2:1] != 2'h0 && !VECTOR_ADDR_O[0] && &VECTOR_ADDR_O[13:3])
    else $error("bad vector address");
  init_vals_a:
    assert property ($rose(CPU_RUN_O) |-> INIT_O.ocmp_value == RSCL_OCMP_RST &&
      INIT_O.baud == RSCL_BAUD_RST && INIT_O.ccr_x && INIT_O.ccr_i && INIT_O.ccr_s)
    else $error("start-up values wrong");
  apb_wait_a:
    assert property (PSEL_I && PENABLE_I && !$past(PENABLE_I) |-> !PREADY_O ##1 PREADY_O)
    else $error("apb answer timing");
  cfg_read_a:
    assert property (PREADY_O && !PWRITE_I && PADDR_I == RSCL_CFG_ADDR |->
      PRDATA_O == {24'h000000, CFG_O})
    else $error("read data not latch value");
  cfg_lock_a:
    assert property (PREADY_O && PWRITE_I && PADDR_I == RSCL_CFG_ADDR && !MODE_O[1]
      |=> $stable(CFG_O))
    else $error("latch written in normal mode");
  cfg_write_a:
    assert property (PREADY_O && PWRITE_I && PSTRB_I[0] && PADDR_I == RSCL_CFG_ADDR &&
      MODE_O[1] |=> {24'h000000, CFG_O} == ($past(PWDATA_I) & 32'h000000FF))
    else $error("special write lost");
  map_mem_a:
    assert property (rst_r |-> MAP_O.rom_at_4000 == cfg_r.rom_base_select &&
      MAP_O.rom_in_map == cfg_r.rom_in_map && MAP_O.eeprom_in_map == cfg_r.eeprom_in_map)
    else $error("memory map decode wrong");
  map_ctl_a:
    assert property (rst_r |-> MAP_O.i2c_on_port_d == cfg_r.sync_serial_pin_select &&
      MAP_O.i2c_on_port_e == !cfg_r.sync_serial_pin_select &&
      MAP_O.fast_clock_oe == cfg_r.fast_clock_output_enable &&
      MAP_O.pullup_assign_en == cfg_r.pullup_assign_enable &&
      MAP_O.watchdog_en == !cfg_r.watchdog_off)
    else $error("control decode wrong");
endmodule : rscl_top_sva

bind rscl_top rscl_top_sva u_sva (.SYS_CLK_I, .RST_N_I, .MODE_PIN_A_I, .MODE_PIN_B_I,
  .EEPROM_CFG_I, .PSEL_I, .PENABLE_I, .PWRITE_I, .PADDR_I, .PWDATA_I, .PSTRB_I,
  .PREADY_O, .PRDATA_O, .PERIPH_RST_O, .CPU_FETCH_O, .CPU_RUN_O, .VECTOR_ADDR_O,
  .CFG_O, .MAP_O, .INIT_O, .MODE_O);

// [verification/testbench.sv]
// Self-checking testbench for the reset sequencer
`timescale 1ns/1ns

module testbench;
  import rscl_pkg::*;
  // ****************************************
  // Signals and instances
  // ****************************************
  logic clk, rst_n, mode_select_a, mdb, imask, psel, pen, pwr, prog;
  logic [2:0] cz;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [3:0] pstrb;
  logic [7:0] pdat, ee;
  logic pready, pslverr, prst, fetch, run;
  logic [15:0] vec;
  rscl_cfg_s cfg;
  rscl_map_s map;
  rscl_init_s init_o;
  logic [4:0] tirq;
  logic [2:0] mode;
  int err_total = 0;
  int n_compared = 0;
  rscl_eeprom_model u_ee (.clk_i(clk), .prog_i(prog), .data_i(pdat), .cell_o(ee));
  rscl_top uut (.SYS_CLK_I(clk), .RST_N_I(rst_n), .PIN_RESET_I(cz[0]),
    .CLKMON_FAIL_I(cz[1]), .WDOG_TIMEOUT_I(cz[2]), .MODE_PIN_A_I(mode_select_a),
    .MODE_PIN_B_I(mdb), .EEPROM_CFG_I(ee), .CPU_IMASK_I(imask), .PSEL_I(psel),
    .PENABLE_I(pen), .PWRITE_I(pwr), .PADDR_I(paddr), .PWDATA_I(pwdata),
    .PSTRB_I(pstrb), .PREADY_O(pready), .PRDATA_O(prdata), .PSLVERR_O(pslverr),
    .PERIPH_RST_O(prst), .CPU_FETCH_O(fetch), .CPU_RUN_O(run), .VECTOR_ADDR_O(vec),
    .CFG_O(cfg), .MAP_O(map), .INIT_O(init_o), .TOP_IRQ_SEL_O(tirq), .MODE_O(mode));
  initial begin
    clk = 1'h0;
    forever #10 clk = ~clk;
  end
  // ****************************************
  // Tasks
  // ****************************************
  task automatic wrap_up();
    $display("compares %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : wrap_up
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] rd, output logic er);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'h1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'h1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'h1 && n < 20);
    rd = prdata;
    er = pslverr;
    psel <= 1'h0;
    pen <= 1'h0;
    if (n >= 20) begin
      err_total++;
      wrap_up();
    end
  endtask : apb
  // Counts fetch cycles so a short or long fetch is caught, not just the vector
  task automatic wait_run(input logic [15:0] exp_vec);
    int n, f;
    n = 0;
    f = 0;
    do begin
      @(posedge clk);
      n++;
      if (fetch === 1'h1) f++;
    end while (run !== 1'h1 && n < 40);
    if (n >= 40) begin
      err_total++;
      wrap_up();
    end
    chk(f, 32'h3);
    chk(vec, exp_vec);
    chk(prst, 32'h0);
  endtask : wait_run
  task automatic t_reset_state();
    chk(cfg, 8'hB5);
    chk(mode, 3'h0);
    chk(map, 11'h4DA);
    chk({init_o.ccr_x, init_o.ccr_i, init_o.ccr_s}, 3'h7);
    chk({init_o.ram_reg_map_setup, init_o.eeprom_map_setup}, {RSCL_RAM_MAP_RST, 1'h1});
    chk(init_o.expansion_bus, 1'h0);
    chk({init_o.timer_count, init_o.ocmp_value}, {RSCL_TMR_CNT_RST, RSCL_OCMP_RST});
    chk({init_o.baud, init_o.tx_holding_empty, init_o.tx_done}, {RSCL_BAUD_RST, 2'h3});
    chk({init_o.watchdog_rate, init_o.adc_power_up}, {RSCL_WDOG_RATE_RST, 1'h0});
    chk(init_o.osc_startup_delay, 32'h1);
    chk({init_o.clk_monitor_en, init_o.clk_monitor_force}, 32'h0);
    chk({tirq, init_o.irq_edge_mode}, {RSCL_TOP_IRQ_RST, 1'h0});
  endtask : t_reset_state
  task automatic t_latch();
    logic [31:0] rd;
    logic er;
    apb(1'h1, RSCL_CFG_ADDR, 32'h00000000, rd, er);
    apb(1'h0, RSCL_CFG_ADDR, 32'h00000000, rd, er);
    chk(rd, 32'h000000B5);
    @(posedge clk);
    prog <= 1'h1;
    pdat <= 8'h02;
    @(posedge clk);
    prog <= 1'h0;
    apb(1'h0, RSCL_CFG_ADDR, 32'h00000000, rd, er);
    chk(rd, 32'h000000B5);
    apb(1'h0, 12'h100, 32'h00000000, rd, er);
    chk({rd[30:0], er}, 32'h00000001);
    apb(1'h0, RSCL_STAT_ADDR, 32'h00000000, rd, er);
    chk(rd, 32'h00000030);
  endtask : t_latch
  // Special mode strap; watchdog cause only counts once the new byte clears watchdog_off
  task automatic t_causes();
    @(posedge clk);
    mdb <= 1'h0;
    mode_select_a <= 1'h1;
    for (int i = 0; i < 3; i++) begin
      @(posedge clk);
      cz <= 3'h1 << i;
      @(posedge clk);
      cz <= 3'h0;
      wait_run(RSCL_VEC_SPECIAL - 16'(2 * i));
    end
    chk({cfg, mode}, {8'h02, 3'h3});
  endtask : t_causes
  task automatic t_special();
    logic [31:0] rd;
    logic er;
    // A write without the low byte strobe must leave the latches alone
    pstrb <= 4'hE;
    apb(1'h1, RSCL_CFG_ADDR, 32'h00000069, rd, er);
    pstrb <= 4'hF;
    apb(1'h0, RSCL_CFG_ADDR, 32'h00000000, rd, er);
    chk(rd, 32'h00000002);
    apb(1'h1, RSCL_CFG_ADDR, 32'h00000069, rd, er);
    apb(1'h0, RSCL_CFG_ADDR, 32'h00000000, rd, er);
    chk(rd, 32'h00000069);
    chk(map, 11'h2B5);
    apb(1'h0, RSCL_STAT_ADDR, 32'h00000000, rd, er);
    chk(rd, 32'h00000032);
    // Priority bits only move while the CPU masks interrupts
    apb(1'h1, RSCL_PRIO_ADDR, 32'h0000006A, rd, er);
    apb(1'h0, RSCL_PRIO_ADDR, 32'h00000000, rd, er);
    chk(rd, 32'h00000066);
    imask <= 1'h1;
    apb(1'h1, RSCL_PRIO_ADDR, 32'h00000067, rd, er);
    @(posedge clk);
    chk(tirq, 32'h00000007);
    chk(mode, 32'h00000003);
  endtask : t_special
  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    rst_n = 1'h0;
    cz = 3'h0;
    {mode_select_a, imask, psel, pen, pwr, prog} = 6'h00;
    mdb = 1'h1;
    paddr = 12'h000;
    pwdata = 32'h00000000;
    pstrb = 4'hF;
    pdat = 8'h00;
    repeat (12) @(posedge clk);
    rst_n <= 1'h1;
    wait_run(RSCL_VEC_NORMAL);
    t_reset_state();
    t_latch();
    t_causes();
    t_special();
    wrap_up();
  end
endmodule : testbench
